// ### common/dac_defines.svh
// Register map constants for the DMA channel address and count registers
// Assumes byte addressing on a 32-bit AXI4-Lite register bus
`ifndef DAC_DEFINES_SVH
`define DAC_DEFINES_SVH
// Register index inside one channel window (byte address bits 4:2)
`define DAC_REG_SRC 3'h0
`define DAC_REG_DST 3'h1
`define DAC_REG_OFS 3'h2
`define DAC_REG_CNT 3'h3
`define DAC_REG_CTL 3'h4
// Byte addresses of the shared status and mask registers
`define DAC_ADDR_STS 8'h80
`define DAC_ADDR_MSK 8'h84
// Reset value of every 32-bit channel register
`define DAC_RST_WORD 32'h00000000
// Count values with a special meaning
`define DAC_CNT_FREE 32'h00000000
`define DAC_CNT_ONE 32'h00000001
// AXI response codes
`define DAC_RESP_OK 2'h0
`define DAC_RESP_ERR 2'h2
`endif

// ### common/dac_pkg.sv
// Types shared by the DMA channel register block
// Assumes the defines header is compiled alongside
package dac_pkg;
  // Data access size of one item
  typedef enum logic [1:0] {
    DAC_SZ_BYTE = 2'h0,
    DAC_SZ_WORD = 2'h1,
    DAC_SZ_LONG = 2'h2
  } dac_size_e;
  // Address update method
  typedef enum logic [1:0] {
    DAC_UPD_FIX = 2'h0,
    DAC_UPD_INC = 2'h1,
    DAC_UPD_OFS = 2'h2
  } dac_upd_e;
  // Channel control word, bit 0 is the enable
  typedef struct packed {
    dac_upd_e dst_upd;
    dac_upd_e src_upd;
    logic direction_select;
    logic single_mode;
    dac_size_e size;
    logic enable;
  } dac_ctl_s;
  // One channel's registers
  typedef struct packed {
    logic [31:0] source_address;
    logic [31:0] destination_address;
    logic [31:0] address_offset;
    logic [31:0] total_transfer_count;
    dac_ctl_s ctl;
  } dac_chan_s;
endpackage : dac_pkg

// ### verilog/dac_regs.sv
// Four-channel DMA address and count registers with AXI4-Lite slave
// Assumes a synchronous item strobe from the transfer engine
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "dac_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module dac_regs
  import dac_pkg::*;
#(
  parameter int NCH = 4
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic item_valid,
  input wire logic [1:0] item_ch,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic [NCH-1:0] ch_active,
  output logic [NCH-1:0][31:0] src_addr,
  output logic [NCH-1:0][31:0] dst_addr,
  output logic [NCH-1:0] src_used,
  output logic [NCH-1:0] dst_used,
  output logic irq
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  // Channel windows must stay below the shared registers
  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("NCH must be 1 to 4");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    dac_chan_s [NCH-1:0] ch;
    logic [NCH-1:0] sts;
    logic [NCH-1:0] msk;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dac_state_s;

  dac_state_s s_q; // Registered state
  dac_state_s s_d; // Next state
  dac_chan_s cur; // Channel named by the item strobe
  logic hit; // An item moved on an enabled channel
  logic [31:0] sz; // Access size in bytes
  logic wr_go; // Write address and data taken
  logic rd_go; // Read address taken

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction : merge

  // Bytes per item for the access size
  function automatic logic [31:0] size_bytes(input dac_size_e s);
    logic [31:0] r;
    r = 32'h00000001;
    case (s)
      DAC_SZ_WORD: r = 32'h00000002;
      DAC_SZ_LONG: r = 32'h00000004;
      default: r = 32'h00000001;
    endcase
    return r;
  endfunction : size_bytes

  // Address step for one side
  function automatic logic [31:0] step(input dac_upd_e u,
    input logic [31:0] bytes, input logic [31:0] ofs);
    logic [31:0] r;
    r = 32'h00000000;
    case (u)
      DAC_UPD_INC: r = bytes;
      DAC_UPD_OFS: r = ofs;
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction : step

  // ************************************************************
  // Output decode
  // ************************************************************
  // Addresses come straight from the registers; use flags decode mode
  always_comb
  begin
    for (int c = 0; c < NCH; c++) begin
      ch_active[c] = s_q.ch[c].ctl.enable;
      src_addr[c] = s_q.ch[c].source_address;
      dst_addr[c] = s_q.ch[c].destination_address;
      // The external device stands in for the unused side
      src_used[c] = !(s_q.ch[c].ctl.single_mode &&
                      s_q.ch[c].ctl.direction_select);
      dst_used[c] = !(s_q.ch[c].ctl.single_mode &&
                      !s_q.ch[c].ctl.direction_select);
    end
  end

  assign cur = s_q.ch[item_ch];
  assign sz = size_bytes(cur.ctl.size);
  assign hit = ce && item_valid && cur.ctl.enable &&
               (32'(item_ch) < NCH);
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && !s_q.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign irq = |(s_q.sts & s_q.msk);

  // ************************************************************
  // Next state
  // ************************************************************
  // Bus access first, then the item update so hardware wins
  always_comb
  begin
    logic [2:0] ri;
    logic [1:0] wc;
    logic [1:0] rc;
    logic [NCH-1:0] set;
    ri = s_axi_awaddr[4:2];
    wc = s_axi_awaddr[6:5];
    rc = s_axi_araddr[6:5];
    set = '0;
    s_d = s_q;
    // Responses retire on their ready
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    // Write decode
    if (wr_go)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = `DAC_RESP_OK;
      if (s_axi_awaddr == `DAC_ADDR_MSK)
        s_d.msk = NCH'(merge(32'(s_q.msk), s_axi_wdata, s_axi_wstrb));
      else if (s_axi_awaddr == `DAC_ADDR_STS)
      begin
        // Status clears only by reading; writes are ignored
      end
      else if (!s_axi_awaddr[7] && 32'(wc) < NCH &&
               ri <= `DAC_REG_CTL)
      begin
        if (ri == `DAC_REG_SRC)
          s_d.ch[wc].source_address = merge(
            s_q.ch[wc].source_address, s_axi_wdata, s_axi_wstrb);
        else if (ri == `DAC_REG_DST)
          s_d.ch[wc].destination_address = merge(
            s_q.ch[wc].destination_address, s_axi_wdata,
            s_axi_wstrb);
        else if (ri == `DAC_REG_OFS)
          s_d.ch[wc].address_offset = merge(
            s_q.ch[wc].address_offset, s_axi_wdata, s_axi_wstrb);
        else if (ri == `DAC_REG_CNT)
          s_d.ch[wc].total_transfer_count = merge(
            s_q.ch[wc].total_transfer_count, s_axi_wdata,
            s_axi_wstrb);
        else
          // Only the low nine bits exist in the control word
          s_d.ch[wc].ctl = dac_ctl_s'(9'(merge(32'(s_q.ch[wc].ctl),
            s_axi_wdata, s_axi_wstrb)));
      end
      else
        s_d.bresp = `DAC_RESP_ERR;
    end
    // Read decode; a status read clears it
    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `DAC_RESP_OK;
      s_d.rdata = 32'h00000000;
      if (s_axi_araddr == `DAC_ADDR_MSK)
        s_d.rdata = 32'(s_q.msk);
      else if (s_axi_araddr == `DAC_ADDR_STS)
      begin
        s_d.rdata = 32'(s_q.sts);
        s_d.sts = '0;
      end
      else if (!s_axi_araddr[7] && 32'(rc) < NCH &&
               s_axi_araddr[4:2] <= `DAC_REG_CTL)
      begin
        case (s_axi_araddr[4:2])
          `DAC_REG_SRC: s_d.rdata = s_q.ch[rc].source_address;
          `DAC_REG_DST: s_d.rdata = s_q.ch[rc].destination_address;
          `DAC_REG_OFS: s_d.rdata = s_q.ch[rc].address_offset;
          // Live remaining byte count
          `DAC_REG_CNT: s_d.rdata = s_q.ch[rc].total_transfer_count;
          default: s_d.rdata = 32'(s_q.ch[rc].ctl);
        endcase
      end
      else
        s_d.rresp = `DAC_RESP_ERR;
    end
    // Item update on the strobed channel
    if (hit)
    begin
      if (src_used[item_ch])
        s_d.ch[item_ch].source_address = cur.source_address +
          step(cur.ctl.src_upd, sz, cur.address_offset);
      if (dst_used[item_ch])
        s_d.ch[item_ch].destination_address = cur.destination_address +
          step(cur.ctl.dst_upd, sz, cur.address_offset);
      // Free running: counter stays frozen at zero
      if (cur.total_transfer_count == `DAC_CNT_FREE)
        s_d.ch[item_ch].total_transfer_count = `DAC_CNT_FREE;
      else if (cur.total_transfer_count <= sz)
      begin
        // Last item: end the channel and flag it
        s_d.ch[item_ch].total_transfer_count = `DAC_CNT_FREE;
        s_d.ch[item_ch].ctl.enable = 1'b0;
        set[item_ch] = 1'b1;
      end
      else
        s_d.ch[item_ch].total_transfer_count =
          cur.total_transfer_count - sz;
    end
    // Set wins over a clearing read
    s_d.sts = s_d.sts | set;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Whole state clears on reset and holds while ce is low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cnt_dec: assert property (hit && cur.total_transfer_count > sz |=>
    s_q.ch[$past(item_ch)].total_transfer_count ==
    $past(cur.total_transfer_count) - $past(sz))
    else $error("count not reduced by access size");

  a_free_run: assert property (hit && cur.total_transfer_count == 0 |=>
    s_q.ch[$past(item_ch)].total_transfer_count == 0 &&
    s_q.ch[$past(item_ch)].ctl.enable)
    else $error("free running channel stopped");

  a_end_flag: assert property (hit && cur.total_transfer_count != 0 &&
    cur.total_transfer_count <= sz |=> s_q.sts[$past(item_ch)] &&
    !s_q.ch[$past(item_ch)].ctl.enable)
    else $error("end flag missing");

  a_src_ignored: assert property (hit && !src_used[item_ch] |=>
    s_q.ch[$past(item_ch)].source_address == $past(cur.source_address))
    else $error("ignored source moved");

  a_dst_ignored: assert property (hit && !dst_used[item_ch] |=>
    s_q.ch[$past(item_ch)].destination_address ==
    $past(cur.destination_address))
    else $error("ignored destination moved");

  a_src_incr: assert property (hit && src_used[item_ch] &&
    cur.ctl.src_upd == DAC_UPD_INC |=>
    s_q.ch[$past(item_ch)].source_address ==
    $past(cur.source_address) + $past(sz))
    else $error("source not advanced");

  a_dst_offset: assert property (hit && dst_used[item_ch] &&
    cur.ctl.dst_upd == DAC_UPD_OFS |=>
    s_q.ch[$past(item_ch)].destination_address ==
    $past(cur.destination_address) + $past(cur.address_offset))
    else $error("destination offset wrong");

  a_sts_clear: assert property (ce && rd_go && !hit &&
    s_axi_araddr == `DAC_ADDR_STS |=> s_q.sts == '0)
    else $error("status not cleared by read");

  a_rd_answer: assert property (rd_go && ce |=> s_axi_rvalid)
    else $error("read not answered");

endmodule : dac_regs
`default_nettype wire

// ### verification/dac_item_model.sv
// Item strobe source standing in for the transfer engine
// Assumes one clock and an active high asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module dac_item_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  input wire logic [1:0] ch,
  input wire logic [7:0] n,
  output logic item_valid,
  output logic [1:0] item_ch,
  output logic busy
);
  logic [7:0] left_q; // Items still to send
  // Sends n strobes, one idle cycle after each when slow
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      left_q <= 8'h00;
      item_valid <= 1'b0;
      item_ch <= 2'h0;
      busy <= 1'b0;
    end
    else if (go)
    begin
      left_q <= n;
      item_ch <= ch;
      busy <= 1'b1;
    end
    else if (busy && !(slow && item_valid) && left_q != 8'h00)
    begin
      item_valid <= 1'b1;
      left_q <= left_q - 8'h01;
    end
    else
    begin
      item_valid <= 1'b0;
      busy <= busy && left_q != 8'h00;
      if (!busy)
        item_ch <= ~item_ch; // Idle channel lines keep moving
    end
endmodule : dac_item_model
`default_nettype wire

// ### verification/dac_regs_bench.sv
// Self-checking bench for the DMA address and count registers
// Assumes dac_regs and the item model; CPU side is AXI4-Lite
`include "dac_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module dma_channel_address_count_regs_bench
  import dac_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [1:0] gch = 2'h0;
  logic [7:0] gn = 8'h00;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awr, wr, bv, arr, rv, irq, iv, busy;
  logic [1:0] bresp, rresp, ich;
  logic [31:0] rdata, s, d, o, b, v;
  logic [3:0] act, su, du;
  logic [3:0][31:0] sa, da;
  logic [33:0] exp_q[$]; // Expected {resp, data} of each read
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  dac_regs DUT (.clk(clk), .rst(rst), .ce(1'b1), .item_valid(iv),
    .item_ch(ich), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(araddr), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ch_active(act), .src_addr(sa), .dst_addr(da), .src_used(su),
    .dst_used(du), .irq(irq));
  dac_item_model eng (.clk(clk), .rst(rst), .go(go), .slow(slow),
    .ch(gch), .n(gn), .item_valid(iv), .item_ch(ich), .busy(busy));
  // ************************
  // Tasks
  // ************************
  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask : cmp_val
  task automatic cmp_read(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask : cmp_read
  // Register write, held until taken, then wait for the response
  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awaddr <= a;
    wdata <= x;
    bready <= 1'b1;
    do @(posedge clk); while (awr !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge clk); while (bv !== 1'b1);
    bready <= 1'b0;
    cmp_val(32'(bresp), (a > `DAC_ADDR_MSK ||
      (a < `DAC_ADDR_STS && a[4:2] > `DAC_REG_CTL)) ? 32'h2 : 32'h0);
  endtask : axw
  // Register read; the watcher compares against the noted value
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    arv <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rready <= 1'b0;
  endtask : axr
  // Engine moves n items on a channel; CPU stays off its registers
  task automatic run(input logic [1:0] c, input logic [7:0] n);
    @(posedge clk);
    gch <= c;
    gn <= n;
    go <= 1'b1;
    slow <= 1'($urandom_range(1));
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy !== 1'b0);
  endtask : run
  function automatic logic [7:0] ad(input int c, input int r);
    return 8'(c * 32 + r * 4);
  endfunction : ad
  // Control word: enable, size, single, direction, updates
  function automatic logic [31:0] cw(input int z, input int up,
    input int sm, input int dr);
    return 32'({2'(up), 2'(up), 1'(dr), 1'(sm), 2'(z), 1'b1});
  endfunction : cw
  // ************************
  // Checking and stimulus
  // ************************
  initial
    forever #10 clk = ~clk;
  always @(posedge clk)
    if (rv === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
      cmp_read({rresp, rdata}, exp_q.pop_front());
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'hFDA5));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      axr(ad(i / 4, i % 4), 34'h0);
    for (int i = 4; i < 16; i++)
    begin
      v = $urandom;
      axw(ad(i / 4, i % 4), v);
      axr(ad(i / 4, i % 4), {2'h0, v});
    end
    axr(8'h90, {`DAC_RESP_ERR, 32'h0});
    axw(8'h90, 32'h0);
    for (int z = 0; z < 3; z++)
    begin
      s = $urandom;
      d = $urandom;
      b = 32'h1 << z;
      axw(ad(0, 0), s);
      axw(ad(0, 1), d);
      axw(ad(0, 3), 32'hFFFFFFFF);
      axw(ad(0, 4), cw(z, 1, 0, 0));
      run(2'h0, 8'h03);
      cmp_val(sa[0], s + 3 * b);
      cmp_val(da[0], d + 3 * b);
      axr(ad(0, 3), {2'h0, 32'hFFFFFFFF - 3 * b});
    end
    o = $urandom;
    axw(ad(2, 2), o);
    axw(ad(2, 3), 32'h40);
    axw(ad(2, 4), cw(2, 2, 0, 0));
    s = sa[2];
    d = da[2];
    run(2'h2, 8'h02);
    cmp_val(sa[2], s + 2 * o);
    cmp_val(da[2], d + 2 * o);
    axr(ad(2, 3), {2'h0, 32'h38});
    axw(ad(1, 3), `DAC_CNT_FREE);
    axw(ad(1, 4), cw(0, 1, 0, 0));
    s = sa[1];
    run(2'h1, 8'h05);
    cmp_val(sa[1], s + 5);
    cmp_val(32'(act[1]), 32'h1);
    axr(ad(1, 3), 34'h0);
    for (int m = 0; m < 3; m++)
    begin
      axw(ad(1, 4), cw(0, 1, m > 0, m == 2));
      cmp_val(32'(su[1]), 32'(m < 2));
      cmp_val(32'(du[1]), 32'(m != 1));
    end
    axw(`DAC_ADDR_MSK, 32'h0);
    axw(ad(3, 3), `DAC_CNT_ONE);
    axw(ad(3, 4), cw(0, 1, 0, 0));
    run(2'h3, 8'h01);
    cmp_val(32'(act[3]), 32'h0);
    cmp_val(32'(irq), 32'h0);
    axw(`DAC_ADDR_MSK, 32'h8);
    cmp_val(32'(irq), 32'h1);
    axr(`DAC_ADDR_STS, {2'h0, 32'h8});
    @(posedge clk);
    cmp_val(32'(irq), 32'h0);
    axr(ad(3, 3), 34'h0);
    @(posedge clk);
    print_verdict();
  end
endmodule : dma_channel_address_count_regs_bench
`default_nettype wire
